// File: src/acr_pkg.sv
package acr_pkg;
   localparam int ADDR_W = 13;
   localparam int NUM_DATA_CH = 4;
   localparam int NUM_CLK_CH = 2;
   localparam int NUM_CH = 6;
   localparam logic [3:0] INSTR_LAST = 4'hF;
   localparam logic [3:0] BYTE_LAST = 4'h7;
   localparam logic [12:0] ADDR_CHAN_SEL = 13'h0005;
   localparam logic [12:0] ADDR_POWER = 13'h0008;
   localparam logic [12:0] ADDR_ENH = 13'h000C;
   localparam logic [12:0] ADDR_OUT_MODE = 13'h0014;
   localparam logic [12:0] ADDR_OUT_ADJ = 13'h0015;
   localparam logic [12:0] ADDR_PHASE = 13'h0016;
   localparam logic [12:0] ADDR_SER_OUT = 13'h0021;
   localparam logic [12:0] ADDR_COMMIT = 13'h00FF;
   localparam logic [12:0] ADDR_OVERRIDE = 13'h0100;
   localparam logic [12:0] ADDR_PIN_IO2 = 13'h0101;
   localparam logic [7:0] RST_CHAN_SEL = 8'h3F;
   localparam logic [7:0] RST_POWER = 8'h00;
   localparam logic [7:0] RST_ENH = 8'h00;
   localparam logic [7:0] RST_OUT_MODE = 8'h01;
   localparam logic [7:0] RST_OUT_ADJ = 8'h00;
   localparam logic [7:0] RST_PHASE = 8'h03;
   localparam logic [7:0] RST_SER_OUT = 8'h30;
   localparam logic [7:0] RST_OVERRIDE = 8'h00;
   localparam logic [7:0] RST_PIN_IO2 = 8'h00;
   localparam int POS_POWERDOWN_PIN_FUNC = 5;
   localparam int POS_CHOP = 2;
   localparam int POS_REDUCED = 6;
   localparam int POS_INVERT = 2;
   localparam int POS_FORMAT = 0;
   localparam int POS_TERM = 4;
   localparam int POS_DRIVE = 0;
   localparam int POS_IN_DELAY = 4;
   localparam int POS_LANE = 4;
   localparam int POS_LSB_FIRST = 7;
   localparam int POS_FRAME_2X = 2;
   localparam int POS_COMMIT = 0;
   localparam int POS_OVR_EN = 6;
   localparam int POS_RES = 4;
   localparam int POS_PULL_OFF = 0;
   localparam logic [2:0] DEFAULT_RATE = 3'h6;
   localparam logic [1:0] RES_14 = 2'h1;
   localparam logic [1:0] RES_12 = 2'h2;
   typedef enum logic [1:0] {
      PM_NORMAL = 2'h0,
      PM_POWERDOWN = 2'h1,
      PM_STANDBY = 2'h2,
      PM_DIGRESET = 2'h3
   } acr_pmode_t;
   typedef enum logic [3:0] {
      SP_IDLE = 4'h1,
      SP_INSTR = 4'h2,
      SP_DATA = 4'h4,
      SP_DONE = 4'h8
   } acr_spi_state_t;
endpackage

// File: src/acr_sync.sv
`timescale 1ns/1ps
module acr_sync #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// File: src/acr_reset_sync.sv
`timescale 1ns/1ps
module acr_reset_sync (
   input wire logic clk,
   input wire logic reset_n,
   output logic rst_n
);
   logic stage;

   // Assert at once, release only after two clean edges
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         stage <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         stage <= 1'b1;
         rst_n <= stage;
      end
   end
endmodule

// File: src/acr_config_bank.sv
`timescale 1ns/1ps
module acr_config_bank
   import acr_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sclk,
   input wire logic csb,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   input wire logic powerdown_pin,
   output logic datapath_clk_en,
   output logic datapath_reset,
   output logic outputs_enable,
   output logic full_powerdown,
   output logic standby,
   output logic chop_enable,
   output logic [3:0] reduced_range,
   output logic [3:0] lane_invert,
   output logic [3:0] lane_twos_complement,
   output logic [11:0] driver_termination,
   output logic [1:0] clock_double_drive,
   output logic [2:0] input_clock_delay,
   output logic [3:0] data_clock_phase,
   output logic [2:0] lane_mode,
   output logic lsb_first,
   output logic frame_2x,
   output logic [1:0] serial_bits_code,
   output logic res_override_enable,
   output logic [1:0] res_override_code,
   output logic [2:0] rate_override_code,
   output logic sdio_pulldown_en
);
   logic rst_n;
   logic [3:0] pins_s;
   logic sclk_s;
   logic csb_s;
   logic sdio_s;
   logic pd_pin_s;
   logic sclk_d;
   logic sclk_rise;
   logic sclk_fall;
   acr_spi_state_t state;
   logic [3:0] bit_cnt;
   logic [14:0] instr;
   logic [6:0] rx;
   logic [7:0] tx;
   logic [12:0] addr;
   logic [12:0] next_addr;
   logic is_read;
   logic [1:0] count;
   logic [1:0] bytes_done;
   logic wr_en;
   logic [12:0] wr_addr;
   logic [7:0] wr_data;
   logic [7:0] rd_data;
   logic [7:0] chan_sel;
   logic [7:0] power;
   logic [7:0] enh;
   logic [7:0] phase;
   logic [7:0] ser_out;
   logic [7:0] ovr_staged;
   logic [7:0] ovr_active;
   logic [7:0] pin_io2;
   logic [7:0] out_mode [NUM_DATA_CH];
   logic [7:0] out_adj [NUM_CH];
   logic upgrade;
   acr_pmode_t next_mode;
   logic [1:0] next_double;

   function automatic logic [2:0] first_sel(input logic [7:0] sel,
                                            input int n);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = n - 1; i >= 0; i--) begin
         if (sel[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // Only power-on reset reaches the port and the bank
   acr_reset_sync u_rst (
      .clk(clk),
      .reset_n(reset_n),
      .rst_n(rst_n)
   );

   // Port pins are asynchronous to the converter clock
   acr_sync #(.W(4)) u_pins (
      .clk(clk),
      .rst_n(rst_n),
      .d({powerdown_pin, sdio_in, ~csb, sclk}),
      .q(pins_s)
   );

   assign sclk_s = pins_s[0];
   // Carried inverted so the cleared synchroniser reads as idle
   assign csb_s = ~pins_s[1];
   assign sdio_s = pins_s[2];
   assign pd_pin_s = pins_s[3];
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sclk_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
      end
   end

   // Address of the byte about to be shifted
   always_comb begin
      if (state == SP_INSTR) begin
         next_addr = {instr[11:0], sdio_s};
      end else begin
         next_addr = addr + 13'h0001;
      end
   end

   // Serial frame: 16-bit instruction, then data bytes MSB first
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SP_IDLE;
         bit_cnt <= 4'h0;
         instr <= 15'h0000;
         rx <= 7'h00;
         tx <= 8'h00;
         addr <= 13'h0000;
         is_read <= 1'b0;
         count <= 2'h0;
         bytes_done <= 2'h0;
      end else if (csb_s) begin
         state <= SP_IDLE;
         bit_cnt <= 4'h0;
      end else begin
         case (state)
            SP_IDLE: begin
               state <= SP_INSTR;
               bit_cnt <= 4'h0;
            end
            SP_INSTR: begin
               if (sclk_rise) begin
                  instr <= {instr[13:0], sdio_s};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == INSTR_LAST) begin
                     state <= SP_DATA;
                     bit_cnt <= 4'h0;
                     addr <= next_addr;
                     is_read <= instr[14];
                     count <= instr[13:12];
                     bytes_done <= 2'h0;
                     tx <= rd_data;
                  end
               end
            end
            SP_DATA: begin
               if (sclk_rise) begin
                  rx <= {rx[5:0], sdio_s};
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == BYTE_LAST) begin
                     bit_cnt <= 4'h0;
                     addr <= next_addr;
                     tx <= rd_data;
                     bytes_done <= bytes_done + 2'h1;
                     // Count 11 streams until chip select rises
                     if (count != 2'h3 && bytes_done == count) begin
                        state <= SP_DONE;
                     end
                  end
               end else if (sclk_fall && is_read) begin
                  tx <= {tx[6:0], 1'b0};
               end
            end
            SP_DONE: begin
               state <= SP_DONE;
            end
            default: begin
               state <= SP_IDLE;
            end
         endcase
      end
   end

   // Read data leaves on falling edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdio_out <= 1'b0;
         sdio_oe <= 1'b0;
      end else if (csb_s) begin
         sdio_oe <= 1'b0;
      end else if (state == SP_DATA && is_read && sclk_fall) begin
         sdio_out <= tx[7];
         sdio_oe <= 1'b1;
      end
   end

   // One write pulse per completed data byte
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_en <= 1'b0;
         wr_addr <= 13'h0000;
         wr_data <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (!csb_s && state == SP_DATA && sclk_rise && !is_read &&
             bit_cnt == BYTE_LAST) begin
            wr_en <= 1'b1;
            wr_addr <= addr;
            wr_data <= {rx, sdio_s};
         end
      end
   end

   // Readback; per-channel registers show the lowest selected channel
   always_comb begin
      if (next_addr == ADDR_CHAN_SEL) begin
         rd_data = chan_sel;
      end else if (next_addr == ADDR_POWER) begin
         rd_data = power;
      end else if (next_addr == ADDR_ENH) begin
         rd_data = enh;
      end else if (next_addr == ADDR_OUT_MODE) begin
         rd_data = out_mode[2'(first_sel(chan_sel, NUM_DATA_CH))];
      end else if (next_addr == ADDR_OUT_ADJ) begin
         rd_data = out_adj[first_sel(chan_sel, NUM_CH)];
      end else if (next_addr == ADDR_PHASE) begin
         rd_data = phase;
      end else if (next_addr == ADDR_SER_OUT) begin
         rd_data = ser_out;
      end else if (next_addr == ADDR_OVERRIDE) begin
         rd_data = ovr_staged;
      end else if (next_addr == ADDR_PIN_IO2) begin
         rd_data = pin_io2;
      end else begin
         rd_data = 8'h00;
      end
   end

   // Global registers take effect on the write itself
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         chan_sel <= RST_CHAN_SEL;
         power <= RST_POWER;
         enh <= RST_ENH;
         phase <= RST_PHASE;
         ser_out <= RST_SER_OUT;
         pin_io2 <= RST_PIN_IO2;
      end else if (wr_en) begin
         if (wr_addr == ADDR_CHAN_SEL) begin
            chan_sel <= wr_data;
         end else if (wr_addr == ADDR_POWER) begin
            power <= wr_data;
         end else if (wr_addr == ADDR_ENH) begin
            enh <= wr_data;
         end else if (wr_addr == ADDR_PHASE) begin
            phase <= wr_data;
         end else if (wr_addr == ADDR_SER_OUT) begin
            ser_out <= wr_data;
         end else if (wr_addr == ADDR_PIN_IO2) begin
            pin_io2 <= wr_data;
         end
      end
   end

   // Override is staged and applied only by the commit bit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_staged <= RST_OVERRIDE;
         ovr_active <= RST_OVERRIDE;
      end else if (wr_en) begin
         if (wr_addr == ADDR_OVERRIDE) begin
            ovr_staged <= wr_data;
         end else if (wr_addr == ADDR_COMMIT && wr_data[POS_COMMIT]) begin
            ovr_active <= ovr_staged;
         end
      end
   end

   // Per-channel registers follow the channel select bits
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               out_adj[g] <= RST_OUT_ADJ;
            end else if (wr_en && wr_addr == ADDR_OUT_ADJ && chan_sel[g]) begin
               out_adj[g] <= wr_data;
            end
         end
         assign driver_termination[2*g +: 2] =
            out_adj[g][POS_TERM +: 2];
      end
      for (g = 0; g < NUM_DATA_CH; g++) begin : g_lane
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               out_mode[g] <= RST_OUT_MODE;
            end else if (wr_en && wr_addr == ADDR_OUT_MODE &&
                         chan_sel[g]) begin
               out_mode[g] <= wr_data;
            end
         end
         assign reduced_range[g] = out_mode[g][POS_REDUCED];
         assign lane_invert[g] = out_mode[g][POS_INVERT];
         assign lane_twos_complement[g] = out_mode[g][POS_FORMAT];
      end
   endgenerate

   // Frame clock is channel 4, data clock channel 5
   always_comb begin
      for (int c = 0; c < NUM_CLK_CH; c++) begin
         next_double[c] = out_adj[NUM_DATA_CH + c][POS_DRIVE] &&
            out_adj[NUM_DATA_CH + c][POS_TERM +: 2] == 2'h0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clock_double_drive <= 2'h0;
      end else begin
         clock_double_drive <= next_double;
      end
   end

   // Only a rate above the default or a resolution other than RES_14 or RES_12 counts as an upgrade
   assign upgrade = ovr_active[POS_OVR_EN] &&
      (ovr_active[2:0] > DEFAULT_RATE ||
       (ovr_active[POS_RES +: 2] != RES_14 &&
        ovr_active[POS_RES +: 2] != RES_12));

   always_comb begin
      if (upgrade) begin
         next_mode = PM_POWERDOWN;
      end else if (pd_pin_s) begin
         next_mode = power[POS_POWERDOWN_PIN_FUNC] ? PM_POWERDOWN : PM_STANDBY;
      end else begin
         next_mode = acr_pmode_t'(power[1:0]);
      end
   end

   // Mode decode never touches the serial port or the bank
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         datapath_clk_en <= 1'b0;
         datapath_reset <= 1'b1;
         outputs_enable <= 1'b0;
         full_powerdown <= 1'b0;
         standby <= 1'b0;
      end else begin
         datapath_clk_en <= next_mode == PM_NORMAL;
         datapath_reset <= next_mode == PM_POWERDOWN ||
            next_mode == PM_DIGRESET;
         outputs_enable <= next_mode == PM_NORMAL;
         full_powerdown <= next_mode == PM_POWERDOWN;
         standby <= next_mode == PM_STANDBY;
      end
   end

   assign chop_enable = enh[POS_CHOP];
   assign input_clock_delay = phase[POS_IN_DELAY +: 3];
   assign data_clock_phase = phase[3:0];
   assign lane_mode = ser_out[POS_LANE +: 3];
   assign lsb_first = ser_out[POS_LSB_FIRST];
   assign frame_2x = ser_out[POS_FRAME_2X];
   assign serial_bits_code = ser_out[1:0];
   assign res_override_enable = ovr_active[POS_OVR_EN];
   assign res_override_code = ovr_active[POS_RES +: 2];
   assign rate_override_code = ovr_active[2:0];

   // Own flop so the pull-down control leaves a register directly
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sdio_pulldown_en <= ~RST_PIN_IO2[POS_PULL_OFF];
      end else if (wr_en && wr_addr == ADDR_PIN_IO2) begin
         sdio_pulldown_en <= ~wr_data[POS_PULL_OFF];
      end
   end
endmodule

// File: tb/acr_chk.sv
`timescale 1ns/1ps
module acr_chk (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic csb,
   input wire logic sdio_oe,
   input wire logic powerdown_pin,
   input wire logic datapath_clk_en,
   input wire logic datapath_reset,
   input wire logic outputs_enable,
   input wire logic full_powerdown,
   input wire logic standby,
   input wire logic chop_enable,
   input wire logic [3:0] lane_twos_complement,
   input wire logic [11:0] driver_termination,
   input wire logic [1:0] clock_double_drive,
   input wire logic [2:0] input_clock_delay,
   input wire logic [3:0] data_clock_phase,
   input wire logic [2:0] lane_mode,
   input wire logic res_override_enable,
   input wire logic sdio_pulldown_en
);
   logic [12:0] cfg;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   assign cfg = {chop_enable, lane_mode, data_clock_phase,
      input_clock_delay, sdio_pulldown_en, res_override_enable};
   a_pd_outputs: assert property (
      full_powerdown |-> datapath_reset && !outputs_enable
         && !datapath_clk_en)
      else $error("power-down with live datapath");
   a_stby_outputs: assert property (
      standby |-> !datapath_reset && !outputs_enable && !datapath_clk_en)
      else $error("standby with reset or live outputs");
   a_normal_outputs: assert property (
      datapath_clk_en |-> outputs_enable && !datapath_reset
         && !full_powerdown && !standby)
      else $error("normal run with a low-power flag");
   a_pin_forces_off: assert property (
      powerdown_pin [*8] |-> full_powerdown || standby)
      else $error("pin held high without power-down or standby");
   a_frame_term_wins: assert property (
      (|driver_termination[9:8]) [*2] |-> !clock_double_drive[0])
      else $error("frame clock double drive with termination");
   a_data_term_wins: assert property (
      (|driver_termination[11:10]) [*2] |-> !clock_double_drive[1])
      else $error("data clock double drive with termination");
   a_oe_idle_port: assert property (
      csb [*5] |-> !sdio_oe)
      else $error("serial data driven outside a frame");
   a_cfg_in_frame: assert property (
      !$stable(cfg) |-> !csb || !$past(csb, 3))
      else $error("setting changed outside a serial frame");
   a_reset_values: assert property (
      disable iff (1'b0)
      !reset_n [*2] |-> lane_twos_complement == 4'hF
         && data_clock_phase == 4'h3 && input_clock_delay == 3'h0
         && !sdio_oe && datapath_reset)
      else $error("wrong value under reset");
   c_powerdown: cover property (full_powerdown);
   c_standby: cover property (standby);
   c_read: cover property (sdio_oe);
   c_override: cover property (res_override_enable);
endmodule
bind acr_config_bank acr_chk acr_chk_i (.clk, .reset_n, .csb, .sdio_oe,
   .powerdown_pin, .datapath_clk_en, .datapath_reset, .outputs_enable,
   .full_powerdown, .standby, .chop_enable, .lane_twos_complement,
   .driver_termination, .clock_double_drive, .input_clock_delay,
   .data_clock_phase, .lane_mode, .res_override_enable,
   .sdio_pulldown_en);

// File: tb/acr_spi_host.sv
`timescale 1ns/1ps
module acr_spi_host (
   input wire logic clk,
   input wire logic sdio,
   output logic sclk,
   output logic csb,
   output logic host_d,
   output logic host_oe
);
   initial begin
      sclk = 1'b0;
      csb = 1'b1;
      host_d = 1'b0;
      host_oe = 1'b0;
   end
   task automatic gap(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Single-byte frame; 6 clocks per half period keeps sync margin
   task automatic xfer(input logic rd, input logic [12:0] a,
      input logic [7:0] wd, output logic [7:0] rdat);
      logic [23:0] sh;
      sh = {rd, 2'b00, a, wd};
      rdat = 8'h00;
      csb = 1'b0;
      gap(6);
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         host_oe = !(rd && i < 8);
         host_d = sh[i];
         gap(6);
         if (rd && i < 8) begin
            rdat[i] = sdio;
         end
         sclk = 1'b1;
         gap(6);
      end
      sclk = 1'b0;
      host_oe = 1'b0;
      gap(6);
      csb = 1'b1;
      gap(6);
   endtask
   // Two-byte write, count 01; the address steps up per byte
   task automatic wr2(input logic [12:0] a, input logic [15:0] wd);
      logic [31:0] sh;
      sh = {1'b0, 2'b01, a, wd};
      csb = 1'b0;
      host_oe = 1'b1;
      gap(6);
      for (int i = 31; i >= 0; i--) begin
         sclk = 1'b0;
         host_d = sh[i];
         gap(6);
         sclk = 1'b1;
         gap(6);
      end
      sclk = 1'b0;
      host_oe = 1'b0;
      gap(6);
      csb = 1'b1;
      gap(6);
   endtask
endmodule

// File: tb/tb_adc_config_register_bank.sv
`timescale 1ns/1ps
module tb_adc_config_register_bank;
   import acr_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic powerdown_pin = 1'b0;
   int err_count = 0;
   int cmp_count = 0;
   logic sclk, csb, host_d, host_oe, sdio, sdio_out, sdio_oe;
   logic datapath_clk_en, datapath_reset, outputs_enable, full_powerdown;
   logic standby, chop_enable, lsb_first, frame_2x, res_override_enable;
   logic sdio_pulldown_en;
   logic [3:0] reduced_range, lane_invert, lane_twos_complement;
   logic [3:0] data_clock_phase;
   logic [11:0] driver_termination;
   logic [1:0] clock_double_drive, serial_bits_code, res_override_code;
   logic [2:0] input_clock_delay, lane_mode, rate_override_code;
   // Released line: pull-down level, else the inverse of the last bit
   assign sdio = host_oe ? host_d : sdio_oe ? sdio_out :
      sdio_pulldown_en ? 1'b0 : ~host_d;
   always #2.5 clk = ~clk;
   acr_spi_host acr_spi_host_i (.clk, .sdio, .sclk, .csb, .host_d,
      .host_oe);
   acr_config_bank acr_config_bank_i (.clk, .reset_n, .sclk, .csb,
      .sdio_in(sdio), .sdio_out, .sdio_oe, .powerdown_pin,
      .datapath_clk_en, .datapath_reset, .outputs_enable, .full_powerdown,
      .standby, .chop_enable, .reduced_range, .lane_invert,
      .lane_twos_complement, .driver_termination, .clock_double_drive,
      .input_clock_delay, .data_clock_phase, .lane_mode, .lsb_first,
      .frame_2x, .serial_bits_code, .res_override_enable,
      .res_override_code, .rate_override_code, .sdio_pulldown_en);
   task automatic check(input string what, input logic [11:0] exp,
      input logic [11:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] x;
      acr_spi_host_i.xfer(1'b0, a, d, x);
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] e);
      logic [7:0] x;
      acr_spi_host_i.xfer(1'b1, a, 8'h00, x);
      check("readback", {4'h0, e}, {4'h0, x});
   endtask
   // Order: clock enable, reset, outputs, power-down, standby
   task automatic mode_chk(input logic [4:0] e);
      check("mode", {7'h0, e}, {7'h0, datapath_clk_en, datapath_reset,
         outputs_enable, full_powerdown, standby});
   endtask
   task automatic pin(input logic v);
      powerdown_pin = v;
      acr_spi_host_i.gap(12);
   endtask
   task automatic t_reset();
      rd_chk(ADDR_CHAN_SEL, RST_CHAN_SEL);
      rd_chk(ADDR_POWER, 8'h00);
      rd_chk(ADDR_OUT_MODE, 8'h01);
      rd_chk(ADDR_PHASE, 8'h03);
      rd_chk(ADDR_SER_OUT, 8'h30);
      rd_chk(ADDR_COMMIT, 8'h00);
      rd_chk(13'h00FE, 8'h00);
      mode_chk(5'h14);
      check("pulldown", 12'h001, 12'(sdio_pulldown_en));
      $display("test reset done");
   endtask
   task automatic t_power();
      logic [4:0] tbl [4];
      tbl = '{5'h14, 5'h0A, 5'h01, 5'h08};
      for (int m = 0; m < 4; m++) begin
         wr(ADDR_POWER, 8'(m));
         mode_chk(tbl[m]);
      end
      rd_chk(ADDR_POWER, 8'h03);
      wr(ADDR_POWER, 8'h20);
      pin(1'b1);
      mode_chk(5'h0A);
      pin(1'b0);
      wr(ADDR_POWER, 8'h00);
      pin(1'b1);
      mode_chk(5'h01);
      pin(1'b0);
      mode_chk(5'h14);
      $display("test power done");
   endtask
   task automatic t_outmode();
      wr(ADDR_CHAN_SEL, 8'h02);
      wr(ADDR_OUT_MODE, 8'h44);
      check("range", 12'h002, 12'(reduced_range));
      check("invert", 12'h002, 12'(lane_invert));
      check("format", 12'h00D, 12'(lane_twos_complement));
      rd_chk(ADDR_OUT_MODE, 8'h44);
      wr(ADDR_ENH, 8'h04);
      check("chop", 12'h001, 12'(chop_enable));
      wr(ADDR_PHASE, 8'h7B);
      check("phase", 12'h07B,
         12'({input_clock_delay, data_clock_phase}));
      for (int l = 0; l < 5; l++) begin
         wr(ADDR_SER_OUT, 8'(l * 16));
         check("lane", 12'(l), 12'(lane_mode));
      end
      wr(ADDR_SER_OUT, 8'hB6);
      check("ser_out", 12'h03E, 12'({lane_mode, lsb_first, frame_2x,
         serial_bits_code}));
      wr(ADDR_PIN_IO2, 8'h01);
      check("pulldown", 12'h000, 12'(sdio_pulldown_en));
      $display("test output done");
   endtask
   task automatic t_drive();
      wr(ADDR_CHAN_SEL, 8'h10);
      wr(ADDR_OUT_ADJ, 8'h01);
      check("drive", 12'h001, 12'(clock_double_drive));
      wr(ADDR_CHAN_SEL, 8'h30);
      wr(ADDR_OUT_ADJ, 8'h21);
      check("term", 12'hA00, driver_termination);
      check("drive", 12'h000, 12'(clock_double_drive));
      acr_spi_host_i.wr2(ADDR_OUT_ADJ, 16'h0052);
      check("term", 12'h000, driver_termination);
      check("phase", 12'h052,
         12'({input_clock_delay, data_clock_phase}));
      $display("test drive done");
   endtask
   task automatic t_override();
      wr(ADDR_OVERRIDE, 8'h66);
      wr(ADDR_COMMIT, 8'h00);
      check("staged", 12'h000, 12'({res_override_enable, res_override_code,
         rate_override_code}));
      rd_chk(ADDR_OVERRIDE, 8'h66);
      wr(ADDR_COMMIT, 8'h01);
      check("commit", 12'h036, 12'({res_override_enable, res_override_code,
         rate_override_code}));
      mode_chk(5'h14);
      wr(ADDR_OVERRIDE, 8'h47);
      wr(ADDR_COMMIT, 8'h01);
      mode_chk(5'h0A);
      wr(ADDR_OVERRIDE, 8'h00);
      wr(ADDR_COMMIT, 8'h01);
      mode_chk(5'h14);
      $display("test override done");
   endtask
   task automatic print_verdict();
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // About 40 frames of some 300 clocks each fit well inside this
   initial begin
      repeat (60000) @(posedge clk);
      err_count++;
      $display("Watchdog expired");
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      #1;
      reset_n = 1'b1;
      acr_spi_host_i.gap(10);
      t_reset();
      t_power();
      t_outmode();
      t_drive();
      t_override();
      print_verdict();
   end
endmodule
